// File: rtl/iso_alloc_pkg.sv
// iso_alloc_pkg: register map, field layout and sizes for the iso fifo allocator
// assumes a 32-bit axi4-lite register bus with byte addresses
package iso_alloc_pkg;

  localparam int unsigned BUF_BYTES    = 1024;
  localparam int unsigned NUM_EP       = 16;
  localparam int unsigned NUM_BANKS    = 2;
  localparam int unsigned BUF_AW       = 10;
  localparam int unsigned PHYS_AW      = 11;
  localparam int unsigned SIZE_W       = 11;
  localparam int unsigned EP_IDX_W     = 4;
  localparam int unsigned BUS_AW       = 8;

  // base registers: out 8..15 at 0x00..0x1C, then in 8..15 at 0x20..0x3C
  localparam logic [7:0]  BASE_FIRST   = 8'h00;
  localparam logic [7:0]  BASE_LAST    = 8'h3C;
  localparam logic [7:0]  EP8_OUT_FIFO_BASE_OFS  = 8'h00;
  localparam logic [7:0]  EP9_OUT_FIFO_BASE_OFS  = 8'h04;
  localparam logic [7:0]  EP10_OUT_FIFO_BASE_OFS = 8'h08;
  localparam logic [7:0]  EP11_OUT_FIFO_BASE_OFS = 8'h0C;
  localparam logic [7:0]  EP12_OUT_FIFO_BASE_OFS = 8'h10;
  localparam logic [7:0]  EP13_OUT_FIFO_BASE_OFS = 8'h14;
  localparam logic [7:0]  EP14_OUT_FIFO_BASE_OFS = 8'h18;
  localparam logic [7:0]  EP15_OUT_FIFO_BASE_OFS = 8'h1C;
  localparam logic [7:0]  EP8_IN_FIFO_BASE_OFS   = 8'h20;
  localparam logic [7:0]  EP9_IN_FIFO_BASE_OFS   = 8'h24;
  localparam logic [7:0]  EP10_IN_FIFO_BASE_OFS  = 8'h28;
  localparam logic [7:0]  EP11_IN_FIFO_BASE_OFS  = 8'h2C;
  localparam logic [7:0]  EP12_IN_FIFO_BASE_OFS  = 8'h30;
  localparam logic [7:0]  EP13_IN_FIFO_BASE_OFS  = 8'h34;
  localparam logic [7:0]  EP14_IN_FIFO_BASE_OFS  = 8'h38;
  localparam logic [7:0]  EP15_IN_FIFO_BASE_OFS  = 8'h3C;
  localparam logic [7:0]  VALID_OFS    = 8'h40;
  localparam logic [7:0]  STATUS_OFS   = 8'h44;

  // base register field: buffer address bits 9..4 in register bits 7..2
  localparam int unsigned FLD_HI       = 7;
  localparam int unsigned FLD_LO       = 2;
  localparam int unsigned GRAN_SHIFT   = 4;

  localparam logic [7:0]  BASE_RESET   = 8'h00;
  localparam logic [15:0] VALID_RESET  = 16'h0000;
  localparam logic [SIZE_W-1:0] BUF_END = 11'h400;

  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  typedef logic [7:0] base_t;

endpackage : iso_alloc_pkg

// File: rtl/iso_fifo_allocation.sv
// iso_fifo_allocation: start-address registers, fifo size/address resolution
// and the double-buffered 2 x 1024-byte iso buffer, with an axi4-lite slave
// assumes one 200 MHz clock, inputs synchronous to it, a single-cycle i_sof pulse
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module iso_fifo_allocation #(
  parameter int unsigned BUF_BYTES_P = iso_alloc_pkg::BUF_BYTES
) (
  input  wire logic                              i_clk,
  input  wire logic                              i_rst_n,
  input  wire logic [iso_alloc_pkg::BUS_AW-1:0]  s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [iso_alloc_pkg::BUS_AW-1:0]  s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  input  wire logic                              i_sof,
  input  wire logic [iso_alloc_pkg::EP_IDX_W-1:0] i_look_ep,
  input  wire logic [iso_alloc_pkg::BUF_AW-1:0]  i_look_off,
  input  wire logic                              i_look_usb,
  input  wire logic                              i_mem_wr,
  input  wire logic [7:0]                        i_mem_wdata,
  output logic [iso_alloc_pkg::PHYS_AW-1:0]      o_look_addr,
  output logic [iso_alloc_pkg::SIZE_W-1:0]       o_look_size,
  output logic                                   o_look_active,
  output logic [7:0]                             o_mem_rdata,
  output logic                                   o_bank
);
  import iso_alloc_pkg::*;

  // the register format fixes the buffer geometry; refuse any other
  if (BUF_BYTES_P != BUF_BYTES) begin : g_bad_size
    $error("iso_fifo_allocation: buffer size is fixed by the register format");
  end
  if (BUF_BYTES != (1 << BUF_AW)) begin : g_bad_aw
    $error("iso_fifo_allocation: buffer address width does not match buffer size");
  end
  if (PHYS_AW != BUF_AW + 1 || NUM_BANKS != 2) begin : g_bad_banks
    $error("iso_fifo_allocation: exactly two buffer halves are supported");
  end
  if (SIZE_W != BUF_AW + 1) begin : g_bad_size_w
    $error("iso_fifo_allocation: size width must hold a full buffer");
  end
  if (FLD_HI - FLD_LO + 1 + GRAN_SHIFT != BUF_AW) begin : g_bad_field
    $error("iso_fifo_allocation: base field and step do not span the buffer");
  end
  if (NUM_EP != (1 << EP_IDX_W)) begin : g_bad_ep
    $error("iso_fifo_allocation: endpoint count must fill the index width");
  end
  if (BUS_AW < 7) begin : g_bad_bus
    $error("iso_fifo_allocation: bus address too narrow for the register map");
  end

  typedef struct packed {
    base_t [NUM_EP-1:0] base;
    logic [15:0]        valid;
    logic               bank;
    logic               aw_got;
    logic [BUS_AW-1:0]  awaddr;
    logic               w_got;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic [PHYS_AW-1:0] look_addr;
    logic [SIZE_W-1:0]  look_size;
    logic               look_active;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // 2 x 1024 bytes, outside any processor memory space
  logic [7:0] buf_mem [0:NUM_BANKS*BUF_BYTES-1];
  logic [7:0] mem_rdata_reg;

  // expand a base register into its 10-bit buffer address
  function automatic logic [SIZE_W-1:0] base_addr(input base_t b);
    base_addr = {1'b0, b[FLD_HI:FLD_LO], 4'h0};
  endfunction : base_addr

  // size = next start minus own start; last endpoint runs to buffer end
  function automatic logic [SIZE_W-1:0] fifo_size(
    input base_t [NUM_EP-1:0] bases,
    input logic [EP_IDX_W-1:0] idx
  );
    logic [SIZE_W-1:0] next_addr;
    next_addr = BUF_END;
    if (idx != EP_IDX_W'(NUM_EP - 1)) begin
      next_addr = base_addr(bases[idx + 4'h1]);
    end
    // wraps silently when bases are out of order
    fifo_size = next_addr - base_addr(bases[idx]);
  endfunction : fifo_size

  function automatic logic [31:0] read_word(
    input state_t s,
    input logic [BUS_AW-1:0] a,
    output logic ok
  );
    read_word = 32'h0000_0000;
    ok = 1'b1;
    if (a[1:0] != 2'b00) begin
      ok = 1'b0;
    end else if (a >= BASE_FIRST && a <= BASE_LAST) begin
      if (a == EP8_OUT_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[0]};
      end else if (a == EP9_OUT_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[1]};
      end else if (a == EP10_OUT_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[2]};
      end else if (a == EP11_OUT_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[3]};
      end else if (a == EP12_OUT_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[4]};
      end else if (a == EP13_OUT_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[5]};
      end else if (a == EP14_OUT_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[6]};
      end else if (a == EP15_OUT_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[7]};
      end else if (a == EP8_IN_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[8]};
      end else if (a == EP9_IN_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[9]};
      end else if (a == EP10_IN_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[10]};
      end else if (a == EP11_IN_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[11]};
      end else if (a == EP12_IN_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[12]};
      end else if (a == EP13_IN_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[13]};
      end else if (a == EP14_IN_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[14]};
      end else if (a == EP15_IN_FIFO_BASE_OFS) begin
        read_word = {24'h00_0000, s.base[15]};
      end
    end else if (a == VALID_OFS) begin
      read_word = {16'h0000, s.valid};
    end else if (a == STATUS_OFS) begin
      read_word = {31'h0000_0000, s.bank};
    end else begin
      ok = 1'b0;
    end
  endfunction : read_word

  logic               wr_fire;
  logic [BUS_AW-1:0]  wr_addr;
  logic [31:0]        wr_data;
  logic [3:0]         wr_strb;
  logic               rd_ok;
  logic [31:0]        rd_word;
  logic               look_bank;
  logic [BUF_AW-1:0]  look_start;
  logic [SIZE_W-1:0]  look_base;

  always_comb begin
    state_next = state_reg;
    wr_addr = state_reg.aw_got ? state_reg.awaddr : s_axi_awaddr;
    wr_data = state_reg.w_got ? state_reg.wdata : s_axi_wdata;
    wr_strb = state_reg.w_got ? state_reg.wstrb : s_axi_wstrb;
    wr_fire = 1'b0;
    rd_ok = 1'b0;
    rd_word = 32'h0000_0000;

    // write address and data are taken in either order
    if (s_axi_awvalid && state_reg.awready) begin
      state_next.aw_got = 1'b1;
      state_next.awaddr = s_axi_awaddr;
      state_next.awready = 1'b0;
    end
    if (s_axi_wvalid && state_reg.wready) begin
      state_next.w_got = 1'b1;
      state_next.wdata = s_axi_wdata;
      state_next.wstrb = s_axi_wstrb;
      state_next.wready = 1'b0;
    end
    if ((state_reg.aw_got || (s_axi_awvalid && state_reg.awready)) &&
        (state_reg.w_got || (s_axi_wvalid && state_reg.wready)) &&
        !state_reg.bvalid) begin
      wr_fire = 1'b1;
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      if (wr_addr[1:0] != 2'b00) begin
        state_next.bresp = RESP_SLVERR;
      end else if (wr_addr >= BASE_FIRST && wr_addr <= BASE_LAST) begin
        // all eight bits stored; only 7..2 reach the address
        if (wr_strb[0]) begin
          if (wr_addr == EP8_OUT_FIFO_BASE_OFS) begin
            state_next.base[0] = wr_data[7:0];
          end else if (wr_addr == EP9_OUT_FIFO_BASE_OFS) begin
            state_next.base[1] = wr_data[7:0];
          end else if (wr_addr == EP10_OUT_FIFO_BASE_OFS) begin
            state_next.base[2] = wr_data[7:0];
          end else if (wr_addr == EP11_OUT_FIFO_BASE_OFS) begin
            state_next.base[3] = wr_data[7:0];
          end else if (wr_addr == EP12_OUT_FIFO_BASE_OFS) begin
            state_next.base[4] = wr_data[7:0];
          end else if (wr_addr == EP13_OUT_FIFO_BASE_OFS) begin
            state_next.base[5] = wr_data[7:0];
          end else if (wr_addr == EP14_OUT_FIFO_BASE_OFS) begin
            state_next.base[6] = wr_data[7:0];
          end else if (wr_addr == EP15_OUT_FIFO_BASE_OFS) begin
            state_next.base[7] = wr_data[7:0];
          end else if (wr_addr == EP8_IN_FIFO_BASE_OFS) begin
            state_next.base[8] = wr_data[7:0];
          end else if (wr_addr == EP9_IN_FIFO_BASE_OFS) begin
            state_next.base[9] = wr_data[7:0];
          end else if (wr_addr == EP10_IN_FIFO_BASE_OFS) begin
            state_next.base[10] = wr_data[7:0];
          end else if (wr_addr == EP11_IN_FIFO_BASE_OFS) begin
            state_next.base[11] = wr_data[7:0];
          end else if (wr_addr == EP12_IN_FIFO_BASE_OFS) begin
            state_next.base[12] = wr_data[7:0];
          end else if (wr_addr == EP13_IN_FIFO_BASE_OFS) begin
            state_next.base[13] = wr_data[7:0];
          end else if (wr_addr == EP14_IN_FIFO_BASE_OFS) begin
            state_next.base[14] = wr_data[7:0];
          end else if (wr_addr == EP15_IN_FIFO_BASE_OFS) begin
            state_next.base[15] = wr_data[7:0];
          end
        end
      end else if (wr_addr == VALID_OFS) begin
        if (wr_strb[0]) begin
          state_next.valid[7:0] = wr_data[7:0];
        end
        if (wr_strb[1]) begin
          state_next.valid[15:8] = wr_data[15:8];
        end
      end else if (wr_addr == STATUS_OFS) begin
        state_next.bresp = RESP_OKAY;
      end else begin
        state_next.bresp = RESP_SLVERR;
      end
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
      state_next.awready = 1'b1;
      state_next.wready = 1'b1;
    end

    // read: one cycle after the address is taken
    if (s_axi_arvalid && state_reg.arready) begin
      rd_word = read_word(state_reg, s_axi_araddr, rd_ok);
      state_next.arready = 1'b0;
      state_next.rvalid = 1'b1;
      state_next.rdata = rd_word;
      state_next.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
      state_next.arready = 1'b1;
    end

    // halves swap every frame, whatever happened in the last one
    if (i_sof) begin
      state_next.bank = ~state_reg.bank;
    end

    // usb side works on the half the processor is not using
    look_bank = state_reg.bank ^ i_look_usb;
    look_base = base_addr(state_reg.base[i_look_ep]);
    look_start = look_base[BUF_AW-1:0];
    // offset wraps inside the 1024-byte half
    state_next.look_addr = {look_bank, look_start + i_look_off};
    state_next.look_size = fifo_size(state_reg.base, i_look_ep);
    state_next.look_active = state_reg.valid[i_look_ep];
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
      state_reg.base <= {NUM_EP{BASE_RESET}};
      state_reg.valid <= VALID_RESET;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // buffer port follows the resolved address of the previous cycle
  always_ff @(posedge i_clk) begin
    if (i_mem_wr && state_reg.look_active) begin
      buf_mem[state_reg.look_addr] <= i_mem_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_rdata_reg <= 8'h00;
    end else begin
      mem_rdata_reg <= buf_mem[state_reg.look_addr];
    end
  end

  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready  = state_reg.wready;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rdata   = state_reg.rdata;
  assign s_axi_rresp   = state_reg.rresp;
  assign o_look_addr   = state_reg.look_addr;
  assign o_look_size   = state_reg.look_size;
  assign o_look_active = state_reg.look_active;
  assign o_mem_rdata   = mem_rdata_reg;
  assign o_bank        = state_reg.bank;

endmodule : iso_fifo_allocation

`default_nettype wire

// File: bench/iso_fifo_allocation_chk.sv
// iso_fifo_allocation_chk: bus handshake, address map, bank and half-select checks
// assumes it is bound to the allocator top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module iso_fifo_allocation_chk (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        i_sof,
  input wire logic        o_bank,
  input wire logic        i_look_usb,
  input wire logic [10:0] o_look_addr
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_resp_a: assert property (wr_taken |=> s_axi_bvalid) else $error("write response missing");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  rd_resp_a: assert property (rd_taken |=> s_axi_rvalid) else $error("read response missing");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  bad_addr_a: assert property (rd_taken ##0 (s_axi_araddr > 8'h44 || s_axi_araddr[1:0] != 2'h0)
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  good_addr_a: assert property (rd_taken ##0 (s_axi_araddr <= 8'h44 && s_axi_araddr[1:0] == 2'h0)
    |=> s_axi_rresp == 2'h0) else $error("mapped read refused");
  sof_swap_a: assert property (i_sof |=> o_bank == !$past(o_bank)) else $error("halves not swapped");
  bank_hold_a: assert property (!i_sof |=> $stable(o_bank)) else $error("halves swapped without frame");
  half_sel_a: assert property (1'b1 |=> o_look_addr[10] == ($past(o_bank) ^ $past(i_look_usb)))
    else $error("wrong buffer half");
endmodule : iso_fifo_allocation_chk
bind iso_fifo_allocation iso_fifo_allocation_chk iso_fifo_allocation_chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .i_sof(i_sof), .o_bank(o_bank),
  .i_look_usb(i_look_usb), .o_look_addr(o_look_addr));
`default_nettype wire

// File: bench/test_iso_fifo_allocation.sv
// test_iso_fifo_allocation: register-bus and lookup test of the fifo allocator
// assumes the package, the allocator and its checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module test_iso_fifo_allocation;
  import iso_alloc_pkg::*;
  logic i_clk = 0, i_rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, sof = 0, usb = 0, mwr = 0;
  logic awr, wrdy, bv, arr, rv, act, bank;
  logic [7:0] awaddr = 0, araddr = 0, wd8 = 0, mrd;
  logic [31:0] wdata = 0, rdata, d;
  logic [3:0] ws = 4'hF, ep = 0;
  logic [9:0] off = 0;
  logic [10:0] la, ls;
  logic [1:0] bresp, rresp, r;
  int miscompares = 0, check_count = 0, cyc = 0, i;
  base_t b [16] = '{8'h00, 8'h40, 8'h44, 8'h48, 8'h48, 8'h48, 8'h48, 8'h48,
                    8'h48, 8'h88, 8'h8C, 8'h90, 8'h90, 8'h90, 8'h90, 8'h90};
  iso_fifo_allocation iso_fifo_allocation_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .i_sof(sof), .i_look_ep(ep), .i_look_off(off), .i_look_usb(usb),
    .i_mem_wr(mwr), .i_mem_wdata(wd8), .o_look_addr(la), .o_look_size(ls),
    .o_look_active(act), .o_mem_rdata(mrd), .o_bank(bank));
  always #2.5 i_clk = ~i_clk;
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : summarize
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge i_clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    d = rdata;
    r = rresp;
    rr <= 1'b0;
    @(posedge i_clk);
  endtask : rd
  // set lookup inputs, return once the registered answer is visible
  task automatic look(input int e, input logic [9:0] o, input logic u);
    ep <= 4'(e);
    off <= o;
    usb <= u;
    repeat (2) @(posedge i_clk);
  endtask : look
  // size from the next base, last endpoint runs to the buffer end
  function automatic logic [10:0] sz(input int k);
    return (k == 15) ? 11'(1024 - 4 * (b[15] & 8'hFC)) : 11'(4 * ((b[k + 1] & 8'hFC) - (b[k] & 8'hFC)));
  endfunction : sz
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    for (i = 0; i < 18; i++) begin
      rd(8'(4 * i));
      chk(d, 32'h0);
    end
    rd(8'h48);
    chk(r, RESP_SLVERR);
    rd(8'h02);
    chk(r, RESP_SLVERR);
    $display("reset and map test done");
    for (i = 0; i < 16; i++)
      wr(8'(4 * i), 32'(b[i]));
    for (i = 0; i < 16; i++) begin
      rd(8'(4 * i));
      chk(d, 32'(b[i]));
      look(i, 10'h005, 1'b0);
      chk(ls, sz(i));
      chk(la, {1'b0, b[i][7:2], 4'h5});
    end
    b[0] = 8'h4B;
    wr(8'h00, 32'h4B);
    look(0, 10'h005, 1'b0);
    chk(ls, sz(0));
    chk(la, {1'b0, b[0][7:2], 4'h5});
    $display("allocation test done");
    wr(VALID_OFS, 32'h0201);
    for (i = 0; i < 16; i++) begin
      look(i, 10'h000, 1'b0);
      chk(act, 32'((16'h0201 >> i) & 16'h1));
    end
    $display("valid test done");
    look(0, 10'h003, 1'b0);
    mwr <= 1'b1;
    wd8 <= 8'hA5;
    @(posedge i_clk);
    mwr <= 1'b0;
    sof <= 1'b1;
    @(posedge i_clk);
    sof <= 1'b0;
    look(0, 10'h003, 1'b1);
    @(posedge i_clk);
    chk(mrd, 8'hA5);
    chk(bank, 1'b1);
    // endpoint 9 out is not valid: a write through it to the same byte must be dropped
    look(1, 10'h023, 1'b1);
    mwr <= 1'b1;
    wd8 <= 8'h5A;
    @(posedge i_clk);
    mwr <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk(mrd, 8'hA5);
    rd(STATUS_OFS);
    chk(d, 32'h1);
    $display("frame swap test done");
    summarize();
  end
endmodule : test_iso_fifo_allocation
`default_nettype wire
